// File: hw/rwg_map.svh
// Purpose: Register offsets, field positions and address bounds of the write guard
// Assumes: 16-bit register port addresses, 20-bit CPU data addresses
// Notes: Definitions only
`ifndef RWG_MAP_SVH
`define RWG_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RWG_OFS_RAM 16'hF0B0
`define RWG_OFS_A 16'hF0B4
`define RWG_OFS_A_HI 16'hF0B5
`define RWG_OFS_B 16'hF0B6
`define RWG_OFS_B_HI 16'hF0B7

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define RWG_RST_CODE 3'h0
`define RWG_RST_WORD 16'h0000
`define RWG_MASK_A 16'h003F
`define RWG_MASK_B 16'h80EF
`define RWG_CODE_MSB 2
`define RWG_BYTE_MSB 7
`define RWG_HI_LSB 8
`define RWG_WORD_MSB 15

// ----------------------------------------------------------------------------
// Guard bit positions
// ----------------------------------------------------------------------------
`define RWG_A_INT 0
`define RWG_A_CLK 1
`define RWG_A_VLS 2
`define RWG_A_PAR 3
`define RWG_A_BLK 4
`define RWG_A_WDT 5
`define RWG_B_XT 15

// ----------------------------------------------------------------------------
// Region codes and RAM bounds
// ----------------------------------------------------------------------------
`define RWG_CODE_OFF 3'h0
`define RWG_CODE_64 3'h1
`define RWG_CODE_128 3'h2
`define RWG_CODE_256 3'h3
`define RWG_CODE_512 3'h4
`define RWG_RAM_TOP 20'h0EFFF
`define RWG_BASE_64 20'h0EFC0
`define RWG_BASE_128 20'h0EF80
`define RWG_BASE_256 20'h0EF00
`define RWG_BASE_512 20'h0EE00

`endif

// File: hw/rwg_pkg.sv
// Purpose: Types shared by the write guard
// Assumes: Constants come from rwg_map.svh
// Notes: None
package rwg_pkg;

  typedef logic [15:0] rwg_word_t;
  typedef logic [19:0] rwg_addr_t;
  typedef logic [2:0] rwg_code_t;

  typedef struct packed {
    rwg_code_t ram_code;
    rwg_word_t guard_a;
    rwg_word_t guard_b;
    rwg_word_t rdata;
  } rwg_state_t;

endpackage : rwg_pkg

// File: hw/rwg_guard.sv
// Purpose: RAM and peripheral register write guard
// Assumes: Decoder supplies RAM hit and one-hot group hits with each CPU write
// Notes: Blocked writes vanish silently; reads are never touched
`timescale 1ns/1ps
`include "rwg_map.svh"
`default_nettype none

module rwg_guard #(
  parameter int GUARD_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire rwg_pkg::rwg_word_t reg_addr,
  input wire rwg_pkg::rwg_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output rwg_pkg::rwg_word_t reg_rdata,
  input wire logic cpu_wr,
  input wire rwg_pkg::rwg_addr_t cpu_addr,
  input wire logic cpu_ram_hit,
  input wire logic [GUARD_W-1:0] cpu_hit_a,
  input wire logic [GUARD_W-1:0] cpu_hit_b,
  output logic ram_wr_en,
  output logic sfr_wr_en,
  output logic wr_blocked
);
  import rwg_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  rwg_state_t state;
  rwg_state_t next_state;
  logic ram_guarded;
  logic sfr_guarded;
  logic [GUARD_W-1:0] grp_block;

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.rdata = `RWG_RST_WORD;
    if (reg_wr) begin
      case (reg_addr)
        `RWG_OFS_RAM: begin
          next_state.ram_code = reg_wdata[`RWG_CODE_MSB:0];
        end
        `RWG_OFS_A: begin
          next_state.guard_a = reg_wdata & `RWG_MASK_A;
        end
        `RWG_OFS_A_HI: begin
          next_state.guard_a = {reg_wdata[`RWG_BYTE_MSB:0], state.guard_a[`RWG_BYTE_MSB:0]} & `RWG_MASK_A;
        end
        `RWG_OFS_B: begin
          next_state.guard_b = reg_wdata & `RWG_MASK_B;
        end
        `RWG_OFS_B_HI: begin
          next_state.guard_b = {reg_wdata[`RWG_BYTE_MSB:0], state.guard_b[`RWG_BYTE_MSB:0]} & `RWG_MASK_B;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `RWG_OFS_RAM: begin
          next_state.rdata = {13'h0000, state.ram_code};
        end
        `RWG_OFS_A: begin
          next_state.rdata = state.guard_a;
        end
        `RWG_OFS_A_HI: begin
          next_state.rdata = {8'h00, state.guard_a[`RWG_WORD_MSB:`RWG_HI_LSB]};
        end
        `RWG_OFS_B: begin
          next_state.rdata = state.guard_b;
        end
        `RWG_OFS_B_HI: begin
          next_state.rdata = {8'h00, state.guard_b[`RWG_WORD_MSB:`RWG_HI_LSB]};
        end
        default: begin
          next_state.rdata = `RWG_RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= '{ram_code: `RWG_RST_CODE, guard_a: `RWG_RST_WORD,
                 guard_b: `RWG_RST_WORD, rdata: `RWG_RST_WORD};
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;

  // --------------------------------------------------------------------------
  // RAM region decode
  // --------------------------------------------------------------------------
  // Region compare for CPU writes
  always_comb begin
    ram_guarded = 1'b0;
    case (state.ram_code)
      `RWG_CODE_OFF: begin
        ram_guarded = 1'b0;
      end
      `RWG_CODE_64: begin
        ram_guarded = (cpu_addr >= `RWG_BASE_64);
      end
      `RWG_CODE_128: begin
        ram_guarded = (cpu_addr >= `RWG_BASE_128);
      end
      `RWG_CODE_256: begin
        ram_guarded = (cpu_addr >= `RWG_BASE_256);
      end
      default: begin
        ram_guarded = (cpu_addr >= `RWG_BASE_512);
      end
    endcase
    ram_guarded = ram_guarded && (cpu_addr <= `RWG_RAM_TOP);
  end

  // --------------------------------------------------------------------------
  // Register group decode
  // --------------------------------------------------------------------------
  // Per-bit group blocking
  // Register A and B groups by bit
  for (genvar i = 0; i < GUARD_W; i++) begin : g_grp
    assign grp_block[i] = (cpu_hit_a[i] & state.guard_a[i]) | (cpu_hit_b[i] & state.guard_b[i]);
  end
  assign sfr_guarded = |grp_block;

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  // Silent suppression of guarded writes
  assign ram_wr_en = cpu_wr && cpu_ram_hit && !ram_guarded;
  assign sfr_wr_en = cpu_wr && !cpu_ram_hit && !sfr_guarded;
  assign wr_blocked = cpu_wr && ((cpu_ram_hit && ram_guarded) || (!cpu_ram_hit && sfr_guarded));

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_code_off;
    @(posedge clk) disable iff (!resetn)
    (state.ram_code == `RWG_CODE_OFF) && cpu_wr && cpu_ram_hit |-> ram_wr_en;
  endproperty
  a_code_off: assert property (p_code_off) else $error("RAM write lost with guard off");

  property p_code_64;
    @(posedge clk) disable iff (!resetn)
    (state.ram_code == `RWG_CODE_64) && cpu_wr && cpu_ram_hit |->
      (ram_wr_en == (cpu_addr < `RWG_BASE_64 || cpu_addr > `RWG_RAM_TOP));
  endproperty
  a_code_64: assert property (p_code_64) else $error("64-byte region wrong");

  property p_code_128;
    @(posedge clk) disable iff (!resetn)
    (state.ram_code == `RWG_CODE_128) && cpu_wr && cpu_ram_hit |->
      (ram_wr_en == (cpu_addr < `RWG_BASE_128 || cpu_addr > `RWG_RAM_TOP));
  endproperty
  a_code_128: assert property (p_code_128) else $error("128-byte region wrong");

  property p_code_256;
    @(posedge clk) disable iff (!resetn)
    (state.ram_code == `RWG_CODE_256) && cpu_wr && cpu_ram_hit |->
      (ram_wr_en == (cpu_addr < `RWG_BASE_256 || cpu_addr > `RWG_RAM_TOP));
  endproperty
  a_code_256: assert property (p_code_256) else $error("256-byte region wrong");

  property p_code_512;
    @(posedge clk) disable iff (!resetn)
    (state.ram_code >= `RWG_CODE_512) && cpu_wr && cpu_ram_hit |->
      (ram_wr_en == (cpu_addr < `RWG_BASE_512 || cpu_addr > `RWG_RAM_TOP));
  endproperty
  a_code_512: assert property (p_code_512) else $error("512-byte region wrong");

  property p_code_write;
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `RWG_OFS_RAM) |=> (state.ram_code == $past(reg_wdata[`RWG_CODE_MSB:0]));
  endproperty
  a_code_write: assert property (p_code_write) else $error("Selector not stored");

  property p_grp_block;
    @(posedge clk) disable iff (!resetn)
    cpu_wr && !cpu_ram_hit && ((cpu_hit_a & state.guard_a) != '0) |-> !sfr_wr_en && wr_blocked;
  endproperty
  a_grp_block: assert property (p_grp_block) else $error("Guarded group write passed");

  property p_guard_next;
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `RWG_OFS_B) && reg_wdata[`RWG_B_XT] ##1
      (cpu_wr && !cpu_ram_hit && cpu_hit_b[`RWG_B_XT]) |-> !sfr_wr_en;
  endproperty
  a_guard_next: assert property (p_guard_next) else $error("New guard late");

  property p_reset_clear;
    @(posedge clk)
    !resetn |=> (state.ram_code == `RWG_RST_CODE) && (state.guard_a == `RWG_RST_WORD) &&
      (state.guard_b == `RWG_RST_WORD) && (reg_rdata == `RWG_RST_WORD);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Guard not clear after reset");

  property p_reserved_a;
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `RWG_OFS_A) |=> ((reg_rdata & ~`RWG_MASK_A) == `RWG_RST_WORD);
  endproperty
  a_reserved_a: assert property (p_reserved_a) else $error("Reserved A bits nonzero");

  property p_reserved_b;
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `RWG_OFS_B) |=> ((reg_rdata & ~`RWG_MASK_B) == `RWG_RST_WORD);
  endproperty
  a_reserved_b: assert property (p_reserved_b) else $error("Reserved B bits nonzero");

  property p_silent;
    @(posedge clk) disable iff (!resetn)
    wr_blocked |-> !ram_wr_en && !sfr_wr_en && cpu_wr;
  endproperty
  a_silent: assert property (p_silent) else $error("Blocked write still strobed");

  property p_grp_block_b;
    @(posedge clk) disable iff (!resetn)
    cpu_wr && !cpu_ram_hit && ((cpu_hit_b & state.guard_b) != '0) |-> !sfr_wr_en && wr_blocked;
  endproperty
  a_grp_block_b: assert property (p_grp_block_b) else $error("Guarded port write passed");

  property p_grp_pass;
    @(posedge clk) disable iff (!resetn)
    cpu_wr && !cpu_ram_hit && ((cpu_hit_a & state.guard_a) == '0) && ((cpu_hit_b & state.guard_b) == '0) |->
      sfr_wr_en && !wr_blocked;
  endproperty
  a_grp_pass: assert property (p_grp_pass) else $error("Open group write lost");

  property p_ram_only;
    @(posedge clk) disable iff (!resetn)
    cpu_wr && cpu_ram_hit |-> !sfr_wr_en;
  endproperty
  a_ram_only: assert property (p_ram_only) else $error("RAM write strobed register side");

  property p_no_write;
    @(posedge clk) disable iff (!resetn)
    !cpu_wr |-> !ram_wr_en && !sfr_wr_en && !wr_blocked;
  endproperty
  a_no_write: assert property (p_no_write) else $error("Strobe without CPU write");

  property p_read_ram;
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `RWG_OFS_RAM) |=> (reg_rdata == {13'h0000, $past(state.ram_code)});
  endproperty
  a_read_ram: assert property (p_read_ram) else $error("Selector read back wrong");

  property p_read_a;
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `RWG_OFS_A) |=> (reg_rdata == $past(state.guard_a));
  endproperty
  a_read_a: assert property (p_read_a) else $error("Guard A read back wrong");

  property p_read_b;
    @(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == `RWG_OFS_B) |=> (reg_rdata == $past(state.guard_b));
  endproperty
  a_read_b: assert property (p_read_b) else $error("Guard B read back wrong");

  property p_rdata_idle;
    @(posedge clk) disable iff (!resetn)
    !reg_rd |=> (reg_rdata == `RWG_RST_WORD);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not cleared");

  property p_write_a;
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `RWG_OFS_A) |=> (state.guard_a == ($past(reg_wdata) & `RWG_MASK_A));
  endproperty
  a_write_a: assert property (p_write_a) else $error("Guard A not stored");

  property p_write_b;
    @(posedge clk) disable iff (!resetn)
    reg_wr && (reg_addr == `RWG_OFS_B) |=> (state.guard_b == ($past(reg_wdata) & `RWG_MASK_B));
  endproperty
  a_write_b: assert property (p_write_b) else $error("Guard B not stored");

  property p_guard_hold;
    @(posedge clk) disable iff (!resetn)
    !reg_wr |=> $stable(state.ram_code) && $stable(state.guard_a) && $stable(state.guard_b);
  endproperty
  a_guard_hold: assert property (p_guard_hold) else $error("Guard changed without write");

  property p_ram_above_top;
    @(posedge clk) disable iff (!resetn)
    cpu_wr && cpu_ram_hit && (cpu_addr > `RWG_RAM_TOP) |-> ram_wr_en;
  endproperty
  a_ram_above_top: assert property (p_ram_above_top) else $error("Write above RAM top blocked");

  property p_xt_port;
    @(posedge clk) disable iff (!resetn)
    cpu_wr && !cpu_ram_hit && cpu_hit_b[`RWG_B_XT] && state.guard_b[`RWG_B_XT] |-> wr_blocked;
  endproperty
  a_xt_port: assert property (p_xt_port) else $error("Crystal port write passed");

  property p_wdt_guard;
    @(posedge clk) disable iff (!resetn)
    cpu_wr && !cpu_ram_hit && cpu_hit_a[`RWG_A_WDT] && state.guard_a[`RWG_A_WDT] |-> wr_blocked;
  endproperty
  a_wdt_guard: assert property (p_wdt_guard) else $error("Watchdog mode write passed");

endmodule : rwg_guard

`default_nettype wire

// File: tb/rwg_cpu_model.sv
// Purpose: CPU master model driving guard registers and data writes
// Assumes: Single clock, register strobes one cycle long; cpu_wr stays high once the go task first drives it
// Notes: Signals change only right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rwg_cpu_model (
  input wire logic clk,
  input wire rwg_pkg::rwg_word_t reg_rdata,
  output var rwg_pkg::rwg_word_t reg_addr,
  output var rwg_pkg::rwg_word_t reg_wdata,
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic cpu_wr,
  output var rwg_pkg::rwg_addr_t cpu_addr,
  output var logic cpu_ram_hit,
  output var rwg_pkg::rwg_word_t cpu_hit_a,
  output var rwg_pkg::rwg_word_t cpu_hit_b
);
  import rwg_pkg::*;
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_addr = 20'h00000;
    cpu_ram_hit = 1'b0;
    cpu_hit_a = 16'h0000;
    cpu_hit_b = 16'h0000;
  end
  task automatic wr(input rwg_word_t a, input rwg_word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input rwg_word_t a, output rwg_word_t q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask : rd
  task automatic go(input logic ram, input rwg_addr_t a, input rwg_word_t ha, input rwg_word_t hb);
    cpu_wr <= 1'b1;
    cpu_ram_hit <= ram;
    cpu_addr <= a;
    cpu_hit_a <= ha;
    cpu_hit_b <= hb;
  endtask : go
endmodule : rwg_cpu_model
`default_nettype wire

// File: tb/test_ram_and_register_write_guard.sv
// Purpose: Self-checking bench for the write guard
// Assumes: Guard outputs are combinational, read data one cycle late
// Notes: Register and CPU traffic come from the master model
`timescale 1ns/1ps
`include "rwg_map.svh"
`default_nettype none
module test_ram_and_register_write_guard;
  import rwg_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  rwg_word_t reg_addr, reg_wdata, reg_rdata, cpu_hit_a, cpu_hit_b, q;
  logic reg_wr, reg_rd, cpu_wr, cpu_ram_hit, ram_wr_en, sfr_wr_en, wr_blocked;
  rwg_addr_t cpu_addr;
  int failures = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  rwg_guard dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
    .cpu_ram_hit(cpu_ram_hit), .cpu_hit_a(cpu_hit_a), .cpu_hit_b(cpu_hit_b),
    .ram_wr_en(ram_wr_en), .sfr_wr_en(sfr_wr_en), .wr_blocked(wr_blocked));
  rwg_cpu_model cpu_u (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_ram_hit(cpu_ram_hit),
    .cpu_hit_a(cpu_hit_a), .cpu_hit_b(cpu_hit_b));
  task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic rd_chk(input rwg_word_t a, input rwg_word_t exp);
    cpu_u.rd(a, q);
    check("reg_rdata", {4'h0, exp}, {4'h0, q});
    @(posedge clk);
    #1;
    check("reg_rdata_idle", 20'h00000, {4'h0, reg_rdata});
    // Return on a rising edge so the next drive lands there
    @(posedge clk);
  endtask : rd_chk
  task automatic cpu_chk(input logic ram, input rwg_addr_t a, input rwg_word_t ha, input rwg_word_t hb,
                         input logic b);
    cpu_u.go(ram, a, ha, hb);
    #1;
    check("write_enables", {17'h00000, ram & ~b, ~ram & ~b, b}, {17'h00000, ram_wr_en, sfr_wr_en, wr_blocked});
    @(posedge clk);
  endtask : cpu_chk
  function automatic rwg_addr_t base(input int c);
    case (c)
      1: return `RWG_BASE_64;
      2: return `RWG_BASE_128;
      3: return `RWG_BASE_256;
      default: return `RWG_BASE_512;
    endcase
  endfunction : base
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(`RWG_OFS_RAM, 16'h0000);
    rd_chk(`RWG_OFS_A, 16'h0000);
    rd_chk(`RWG_OFS_B, 16'h0000);
    cpu_chk(1'b1, `RWG_RAM_TOP, 16'h0000, 16'h0000, 1'b0);
    cpu_chk(1'b0, 20'h0F000, 16'h0001, 16'h0001, 1'b0);
    for (int c = 1; c < 8; c++) begin
      cpu_u.wr(`RWG_OFS_RAM, 16'hFFF8 | 16'(c));
      rd_chk(`RWG_OFS_RAM, 16'(c));
      cpu_chk(1'b1, base(c) - 20'h00001, 16'h0000, 16'h0000, 1'b0);
      cpu_chk(1'b1, base(c), 16'h0000, 16'h0000, 1'b1);
      cpu_chk(1'b1, `RWG_RAM_TOP, 16'h0000, 16'h0000, 1'b1);
      cpu_chk(1'b1, 20'h0F000, 16'h0000, 16'h0000, 1'b0);
    end
    cpu_u.wr(`RWG_OFS_A, 16'hFFFF);
    rd_chk(`RWG_OFS_A, `RWG_MASK_A);
    cpu_u.wr(`RWG_OFS_B, 16'hFFFF);
    rd_chk(`RWG_OFS_B, `RWG_MASK_B);
    cpu_u.wr(`RWG_OFS_B, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      cpu_u.wr(`RWG_OFS_A, 16'h0001 << i);
      cpu_chk(1'b0, 20'h0F000, 16'h0001 << i, 16'h0000, 1'(`RWG_MASK_A >> i));
      cpu_chk(1'b0, 20'h0F000, 16'h0000, 16'h0001 << i, 1'b0);
    end
    cpu_u.wr(`RWG_OFS_A, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      cpu_u.wr(`RWG_OFS_B, 16'h0001 << i);
      cpu_chk(1'b0, 20'h0F000, 16'h0000, 16'h0001 << i, 1'(`RWG_MASK_B >> i));
      cpu_chk(1'b0, 20'h0F000, 16'h0001 << i, 16'h0000, 1'b0);
    end
    cpu_u.wr(`RWG_OFS_B, 16'h0001);
    cpu_u.wr(`RWG_OFS_B_HI, 16'h00FF);
    rd_chk(`RWG_OFS_B, 16'h8001);
    rd_chk(`RWG_OFS_B_HI, 16'h0080);
    cpu_u.wr(`RWG_OFS_A, 16'h0020);
    cpu_u.wr(`RWG_OFS_A_HI, 16'h00FF);
    rd_chk(`RWG_OFS_A, 16'h0020);
    rd_chk(`RWG_OFS_A_HI, 16'h0000);
    cpu_u.wr(16'hF0B2, 16'hFFFF);
    rd_chk(16'hF0B2, 16'h0000);
    rd_chk(`RWG_OFS_RAM, 16'h0007);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(`RWG_OFS_RAM, 16'h0000);
    rd_chk(`RWG_OFS_A, 16'h0000);
    rd_chk(`RWG_OFS_B, 16'h0000);
    cpu_chk(1'b0, 20'h0F000, 16'h0020, 16'h8000, 1'b0);
    close_out();
  end
endmodule : test_ram_and_register_write_guard
`default_nettype wire
